// ### verilog/motor_start_supervisor.sv
// motor startup supervision: start detect, timers and status flags
`default_nettype none
`include "motor_supervisor_defs.svh"
module motor_start_supervisor #(
  parameter int TICK_CYCLES = `MS_TICK_CYCLES,
  parameter int MS_PER_SEC  = `MS_MS_PER_SECOND
) (
  // clock and reset
  input  wire logic                                       i_clock,
  input  wire logic                                       i_rst_n,
  // measured currents and settings, same clock domain
  input  wire motor_supervisor_pkg::phase_currents_t      i_currents,
  input  wire motor_supervisor_pkg::supervisor_settings_t i_settings,
  // status to trip logic
  output var motor_supervisor_pkg::supervisor_status_t    o_status
);
  import motor_supervisor_pkg::*;

  // overview: the largest phase magnitude is compared with two limits,
  // each scaled from the motor rated current. a rise through the idle
  // limit starts the startup timer; its expiry, or a drop below idle
  // before expiry, loads the restart inhibit timer. both timers count
  // millisecond ticks from the local divider.
  //
  // timing at the ports: a current step is registered by the comparators
  // at the first edge and shows on the status flags at the second edge.
  // the first millisecond of either timer may be partial, so a count of
  // n milliseconds lasts between n-1 and n of them.
  //
  // limitation: limit settings are levels and are not captured at the start;
  // a limit changed during a start takes effect on the next cycle.

  // widths of the internal arithmetic
  localparam int CW = 16;  // current width
  localparam int LW = 32;  // scaled limit width

  // ---- settings clamped to legal ranges ----
  logic [7:0]  ratio_c;    // motor to transformer ratio
  logic [9:0]  start_c;    // startup limit percent
  logic [5:0]  idle_c;     // idle limit percent
  logic [6:0]  stime_c;    // startup seconds
  logic [12:0] rtime_c;    // restart seconds
  logic        oper_on;    // function enabled

  // clamp helper shared by every setting except operation
  function automatic logic [15:0] clamp16(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    if (v < lo) begin
      // below the range: the minimum keeps limits and timers non-zero
      return lo;
    end else if (v > hi) begin
      // above the range: the maximum bounds the scaled products
      return hi;
    end
    // inside the range: taken as set
    return v;
  endfunction : clamp16

  // settings are clamped, not rejected: a corrupted word can never stop
  // a timer at zero or leave a limit at zero, which would make every
  // cycle look like a start. operation is a plain on/off bit.
  always_comb begin
    ratio_c = 8'(clamp16(16'(i_settings.motor_to_transformer_ratio),
                   16'(`MS_RATIO_MIN), 16'(`MS_RATIO_MAX)));
    start_c = 10'(clamp16(16'(i_settings.startup_current_limit),
        16'(`MS_STARTUP_LIM_MIN), 16'(`MS_STARTUP_LIM_MAX)));
    idle_c  = 6'(clamp16(16'(i_settings.idle_current_limit),
        16'(`MS_IDLE_LIM_MIN), 16'(`MS_IDLE_LIM_MAX)));
    stime_c = 7'(clamp16(16'(i_settings.startup_time_setting),
        16'(`MS_STARTUP_T_MIN), 16'(`MS_STARTUP_T_MAX)));
    rtime_c = 13'(clamp16(16'(i_settings.restart_block_time),
        16'(`MS_RESTART_T_MIN), 16'(`MS_RESTART_T_MAX)));
    // operation needs no clamp: both codes are legal
    oper_on = i_settings.function_operation_setting;
  end

  // ---- largest phase and scaled limits ----
  logic [CW-1:0] max_cur;     // largest phase magnitude
  logic [LW-1:0] max_scaled;  // largest magnitude times 100
  logic [LW-1:0] idle_lim;    // idle limit in same units
  logic [LW-1:0] start_lim;   // startup limit in same units

  // limits are percent of rated, rated is percent of transformer
  // both sides of each compare carry a factor of 10000, so no division
  // is needed: cur * 100 against limit percent times ratio percent.
  // the largest phase decides, so one loaded phase is enough to start.
  always_comb begin
    // phase a is the first candidate
    max_cur = i_currents.phase_a;
    if (i_currents.phase_b > max_cur) begin
      // phase b is larger
      max_cur = i_currents.phase_b;
    end
    if (i_currents.phase_c > max_cur) begin
      // phase c is larger
      max_cur = i_currents.phase_c;
    end
    max_scaled = LW'(max_cur) * LW'(100);
    idle_lim   = LW'(idle_c) * LW'(ratio_c);
    start_lim  = LW'(start_c) * LW'(ratio_c);
  end

  // ---- comparators with hysteresis ----
  logic above_idle;   // current above idle limit
  logic above_start;  // current above startup limit

  // idle limit: picks up above the limit, releases at 0.7 of it, so a
  // motor running near idle load does not chatter into false starts.
  // both comparators are cleared while the function is off.
  hysteresis_comparator #(
    .WIDTH       (LW),
    .RELEASE_PCT (`MS_IDLE_REL_PCT)
  ) u_idle_cmp (
    .i_clock  (i_clock),
    .i_rst_n  (i_rst_n),
    .i_enable (oper_on),
    .i_value  (max_scaled),
    .i_limit  (idle_lim),
    .o_above  (above_idle)
  );

  // startup limit: releases at 0.95 of the limit; its level at the
  // moment of expiry decides the prolonged-start alarm
  hysteresis_comparator #(
    .WIDTH       (LW),
    .RELEASE_PCT (`MS_STARTUP_REL_PCT)
  ) u_start_cmp (
    .i_clock  (i_clock),
    .i_rst_n  (i_rst_n),
    .i_enable (oper_on),
    .i_value  (max_scaled),
    .i_limit  (start_lim),
    .o_above  (above_start)
  );

  // ---- millisecond tick divider ----
  logic [31:0] div_reg;   // cycle counter
  logic [31:0] div_next;  // next count
  logic        tick_reg;  // one-cycle millisecond pulse
  logic        tick_next; // next pulse

  // free-running divider: the tick is a one-cycle enable, never a clock.
  // it is not aligned to a start, which is why the first millisecond of
  // each timer may be short
  always_comb begin
    if (div_reg >= 32'(TICK_CYCLES - 1)) begin
      // end of a millisecond: wrap and pulse
      div_next  = '0;
      tick_next = 1'b1;
    end else begin
      // inside a millisecond: keep counting
      div_next  = div_reg + 32'h1;
      tick_next = 1'b0;
    end
  end

  // divider registers; reset restarts the millisecond from zero
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= div_next;
      tick_reg <= tick_next;
    end
  end

  // ---- start sequence and timers ----
  start_state_t  state_reg;      // sequence state
  start_state_t  state_next;
  logic          idle_prev_reg;  // previous above-idle level
  logic          idle_prev_next;
  logic [31:0]   stimer_reg;     // startup timer, milliseconds left
  logic [31:0]   stimer_next;
  logic [31:0]   rtimer_reg;     // restart timer, milliseconds left
  logic [31:0]   rtimer_next;
  logic          long_reg;       // prolonged start latched
  logic          long_next;
  logic          start_evt;      // rising through idle limit
  logic          rt_load;        // restart timer load request

  // start sequence: idle waits for a rise through the idle limit,
  // starting counts the startup time down, timeout holds until the
  // current falls below idle. the restart timer is loaded from here but
  // then runs on its own, through later starts as well: it only flags
  // and never blocks start detection.
  always_comb begin
    // hold state, timers and alarm unless a branch below changes them
    state_next     = state_reg;
    stimer_next    = stimer_reg;
    rtimer_next    = rtimer_reg;
    long_next      = long_reg;
    idle_prev_next = above_idle;
    rt_load        = 1'b0;
    start_evt      = above_idle && !idle_prev_reg;
    if (!oper_on) begin
      // function off: everything quiet
      // timers are cleared, so switching on never resumes an old count
      state_next  = st_idle;
      stimer_next = '0;
      rtimer_next = '0;
      long_next   = 1'b0;
    end else begin
      case (state_reg)
        st_idle: begin
          // a level above idle is not enough: only the rising edge starts
          if (start_evt) begin
            // load the full startup time and forget an old alarm
            state_next  = st_starting;
            stimer_next = 32'(stime_c) * 32'(MS_PER_SEC);
            long_next   = 1'b0;
          end
        end
        st_starting: begin
          if (!above_idle) begin
            // start interrupted before expiry
            state_next = st_idle;
            rt_load    = 1'b1;
          end else if (tick_reg) begin
            // one millisecond gone
            if (stimer_reg <= 32'h1) begin
              // last millisecond: expiry
              stimer_next = '0;
              state_next  = st_timeout;
              rt_load     = 1'b1;
              long_next   = above_start;
            end else begin
              // still counting down
              stimer_next = stimer_reg - 32'h1;
            end
          end
        end
        st_timeout: begin
          // locked rotor clears once current releases the limit
          if (!above_start) begin
            long_next = 1'b0;
          end
          if (!above_idle) begin
            // motor stopped: back to waiting for a start
            state_next = st_idle;
            long_next  = 1'b0;
          end
        end
        default: begin
          // unused code: back to idle
          state_next = st_idle;
        end
      endcase
      // restart inhibit timer runs on its own
      // a new load wins over a decrement in the same cycle, so a start
      // cut short while an older inhibit runs restarts the full time
      if (rt_load) begin
        rtimer_next = 32'(rtime_c) * 32'(MS_PER_SEC);
      end else if (tick_reg && rtimer_reg != '0) begin
        // count down, stop at zero
        rtimer_next = rtimer_reg - 32'h1;
      end
    end
  end

  // sequence registers; the edge detector resets to the idle level of
  // the comparator, so no false start follows reset
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg     <= st_idle;
      stimer_reg    <= '0;
      rtimer_reg    <= '0;
      long_reg      <= 1'b0;
      idle_prev_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      stimer_reg    <= stimer_next;
      rtimer_reg    <= rtimer_next;
      long_reg      <= long_next;
      idle_prev_reg <= idle_prev_next;
    end
  end

  // ---- registered status outputs ----
  supervisor_status_t status_reg;  // output flags
  supervisor_status_t status_next;

  // the flags other than motor_running are built from next values so that each appears on the
  // same edge as the state that it reports, then registered so that
  // every output comes straight from a flip-flop
  always_comb begin
    status_next.startup_in_progress   = (state_next == st_starting);
    status_next.motor_running         = oper_on && above_idle;
    status_next.prolonged_start_alarm = long_next;
    status_next.restart_inhibit       = (rtimer_next != '0);
  end

  // output register; all flags low in reset
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  assign o_status = status_reg;

endmodule : motor_start_supervisor
`default_nettype wire

// ### verilog/motor_supervisor_defs.svh
// constants of the motor start supervisor
// Operation
// - motor rated current: percent of transformer rating
// - start: current rises through idle limit
// - startup timer runs, in-progress flag, then time-out
// - running flag while current above idle limit
// - at expiry, above startup limit: prolonged-start alarm
// - expiry starts restart inhibit timer and flag
// - start interrupted below idle: inhibit timer starts
// - operation Off disables the whole function
// - startup limit 50..1000 percent, default 200
// - idle limit 5..50 percent, default 10
// - startup time 1..100 seconds, default 5
// - restart inhibit time 10..5000 seconds, default 20
// - hysteresis: release 0.95 startup, 0.7 idle
`ifndef MOTOR_SUPERVISOR_DEFS_SVH
`define MOTOR_SUPERVISOR_DEFS_SVH

`define MS_CLOCK_HZ          200000000
`define MS_TICK_US           1000
`define MS_TICK_CYCLES       ((`MS_CLOCK_HZ / 1000000) * `MS_TICK_US)
`define MS_MS_PER_SECOND     1000

`define MS_RATIO_MIN         20
`define MS_RATIO_MAX         150
`define MS_RATIO_DEFAULT     100
`define MS_STARTUP_LIM_MIN   50
`define MS_STARTUP_LIM_MAX   1000
`define MS_STARTUP_LIM_DEF   200
`define MS_IDLE_LIM_MIN      5
`define MS_IDLE_LIM_MAX      50
`define MS_IDLE_LIM_DEF      10
`define MS_STARTUP_T_MIN     1
`define MS_STARTUP_T_MAX     100
`define MS_STARTUP_T_DEF     5
`define MS_RESTART_T_MIN     10
`define MS_RESTART_T_MAX     5000
`define MS_RESTART_T_DEF     20

// release ratios as numerator over 100
`define MS_STARTUP_REL_PCT   95
`define MS_IDLE_REL_PCT      70
`define MS_OPER_ON_DEFAULT   1'b1

`endif

// ### verilog/motor_supervisor_pkg.sv
// types of the motor start supervisor
`default_nettype none
package motor_supervisor_pkg;

  // phase current magnitudes in percent of transformer rating
  typedef struct packed {
    logic [15:0] phase_a;
    logic [15:0] phase_b;
    logic [15:0] phase_c;
  } phase_currents_t;

  // settings
  typedef struct packed {
    logic        function_operation_setting;
    logic [7:0]  motor_to_transformer_ratio;
    logic [9:0]  startup_current_limit;
    logic [5:0]  idle_current_limit;
    logic [6:0]  startup_time_setting;
    logic [12:0] restart_block_time;
  } supervisor_settings_t;

  // status outputs
  typedef struct packed {
    logic startup_in_progress;
    logic motor_running;
    logic prolonged_start_alarm;
    logic restart_inhibit;
  } supervisor_status_t;

  // startup sequence states
  typedef enum logic [1:0] {
    st_idle,
    st_starting,
    st_timeout
  } start_state_t;

endpackage : motor_supervisor_pkg
`default_nettype wire

// ### verilog/hysteresis_comparator.sv
// threshold comparator with release hysteresis
`default_nettype none
`include "motor_supervisor_defs.svh"
module hysteresis_comparator #(
  parameter int WIDTH = 32,
  parameter int RELEASE_PCT = 95
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  // compare inputs
  input  wire logic             i_enable,
  input  wire logic [WIDTH-1:0] i_value,
  input  wire logic [WIDTH-1:0] i_limit,
  // result
  output logic                  o_above
);

  logic             above_reg;  // held comparison
  logic             above_next; // next comparison
  logic [WIDTH+6:0] val_scaled; // value times 100
  logic [WIDTH+6:0] lim_rel;    // limit times release ratio

  // compare in percent units to avoid division
  always_comb begin
    val_scaled = (WIDTH+7)'(i_value) * (WIDTH+7)'(100);
    lim_rel    = (WIDTH+7)'(i_limit) * (WIDTH+7)'(RELEASE_PCT);
    if (!i_enable) begin
      above_next = 1'b0;
    end else if (above_reg) begin
      // release only under the lowered threshold
      above_next = (val_scaled >= lim_rel);
    end else begin
      above_next = (i_value > i_limit);
    end
  end

  // register result
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      above_reg <= 1'b0;
    end else begin
      above_reg <= above_next;
    end
  end

  assign o_above = above_reg;

endmodule : hysteresis_comparator
`default_nettype wire

// ### tb/motor_start_supervisor_checker.sv
// concurrent checks on the motor start supervisor ports
`default_nettype none
module motor_start_supervisor_checker
  import motor_supervisor_pkg::*;
#(
  parameter int TICK_CYCLES = 10,
  parameter int MS_PER_SEC  = 2
) (
  // clock and reset
  input wire logic                 i_clock,
  input wire logic                 i_rst_n,
  // watched ports
  input wire phase_currents_t      i_currents,
  input wire supervisor_settings_t i_settings,
  input wire supervisor_status_t   o_status
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cur_max;   // largest phase
  logic        hi_idle;   // clearly above idle pickup
  logic        op;        // operation on
  logic [31:0] sip_cnt;   // cycles of startup in progress
  logic [31:0] sip_next;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // largest phase and idle pickup
  always_comb begin
    cur_max = i_currents.phase_a;
    if (i_currents.phase_b > cur_max) cur_max = i_currents.phase_b;
    if (i_currents.phase_c > cur_max) cur_max = i_currents.phase_c;
    op = i_settings.function_operation_setting;
    hi_idle = 32'(cur_max) * 100 > 32'(i_settings.idle_current_limit) *
              32'(i_settings.motor_to_transformer_ratio);
    sip_next = o_status.startup_in_progress ? sip_cnt + 1 : 32'h0;
  end
  // startup duration counter
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) sip_cnt <= 32'h0;
    else sip_cnt <= sip_next;
  end
  off_clears_a: assert property ((!op)[*3] |-> o_status == 4'h0)
    else $error("outputs not cleared while off");
  run_above_a: assert property ((op && hi_idle)[*3]
    |-> o_status.motor_running) else $error("running flag missing");
  run_zero_a: assert property ((op && cur_max == 16'h0)[*3]
    |-> !o_status.motor_running) else $error("running flag with no load");
  start_rise_a: assert property ($rose(o_status.startup_in_progress)
    |-> $rose(o_status.motor_running)) else $error("start without rise");
  sip_run_a: assert property (o_status.startup_in_progress
    |-> o_status.motor_running) else $error("start flag without running");
  sip_len_a: assert property (sip_cnt <=
    i_settings.startup_time_setting * MS_PER_SEC * TICK_CYCLES + TICK_CYCLES)
    else $error("startup lasts too long");
  inhibit_a: assert property ($fell(o_status.startup_in_progress)
    && op && $past(op) && $past(op, 2)
    |-> o_status.restart_inhibit) else $error("no restart inhibit");
  alarm_a: assert property ($rose(o_status.prolonged_start_alarm)
    |-> $fell(o_status.startup_in_progress)) else $error("alarm off expiry");
  alarm_run_a: assert property (o_status.prolonged_start_alarm
    |-> o_status.motor_running) else $error("alarm without running");
endmodule : motor_start_supervisor_checker
bind motor_start_supervisor motor_start_supervisor_checker #(
  .TICK_CYCLES(TICK_CYCLES), .MS_PER_SEC(MS_PER_SEC)) chk (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_currents(i_currents),
  .i_settings(i_settings), .o_status(o_status));
`default_nettype wire

// ### tb/motor_current_model.sv
// phase current measurement model: one loaded phase, others dead
`default_nettype none
module motor_current_model
  import motor_supervisor_pkg::*;
(
  // load command
  input  wire logic [15:0]    i_level,
  input  wire logic [1:0]     i_phase,
  // measured magnitudes
  output var phase_currents_t o_currents
);
  timeunit 1ns;
  timeprecision 1ps;
  // only the chosen phase carries current
  always_comb begin
    o_currents = '0;
    case (i_phase)
      2'h1:    o_currents.phase_b = i_level;
      2'h2:    o_currents.phase_c = i_level;
      default: o_currents.phase_a = i_level;
    endcase
  end
endmodule : motor_current_model
`default_nettype wire

// ### tb/motor_start_supervisor_test.sv
// self-checking bench of the motor start supervisor
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module motor_start_supervisor_test;
  timeunit 1ns;
  timeprecision 1ps;
  import motor_supervisor_pkg::*;
  logic                 i_clock;
  logic                 i_rst_n;
  logic [15:0]          level;    // load magnitude
  logic [1:0]           phase;    // loaded phase
  phase_currents_t      currents;
  supervisor_settings_t settings;
  supervisor_status_t   status;
  int                   error_cnt;
  int                   checks_done;
  int                   n;
  motor_current_model src (.i_level(level), .i_phase(phase),
    .o_currents(currents));
  motor_start_supervisor #(.TICK_CYCLES(10), .MS_PER_SEC(2)) uut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_currents(currents),
    .i_settings(settings), .o_status(status));
  // 200 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end
  // n edges, then settle
  task step(input int c);
    repeat (c) @(posedge i_clock);
    #1;
  endtask : step
  // cycles that a status bit stays high
  task hold(input int b, output int c);
    c = 0;
    while (status[b] === 1'b1 && c < 1000) begin
      step(1);
      c++;
    end
  endtask : hold
  task results;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  // start below startup limit, expiry, inhibit length
  task t_normal;
    level = 16'h32; step(3);
    `CHK(status, 4'hc)
    hold(3, n);
    `CHK(n >= 8 && n <= 21, 1'b1)
    `CHK(status, 4'h5)
    hold(0, n);
    `CHK(n >= 188 && n <= 201, 1'b1)
    level = 16'h0; step(4);
  endtask : t_normal
  // current above startup limit at expiry
  task t_long;
    level = 16'h12c; step(3); hold(3, n);
    `CHK(status, 4'h7)
    level = 16'h0; step(4);
    `CHK(status.prolonged_start_alarm, 1'b0)
  endtask : t_long
  // start cut short, then hysteresis of idle limit
  task t_break;
    level = 16'h32; step(3); level = 16'h8; step(4);
    `CHK(status.startup_in_progress, 1'b1)
    level = 16'h0; step(3);
    `CHK(status, 4'h1)
    level = 16'h32; step(3); level = 16'h6; step(4);
    `CHK(status.motor_running, 1'b0)
  endtask : t_break
  // operation off
  task t_off;
    level = 16'h32; step(3); settings.function_operation_setting = 1'b0;
    step(3);
    `CHK(status, 4'h0)
    level = 16'h0; settings.function_operation_setting = 1'b1; step(4);
  endtask : t_off
  // ratio scales limits; largest phase on phase c
  task t_ratio;
    phase = 2'h2; settings.motor_to_transformer_ratio = 8'h32;
    level = 16'h6; step(4);
    `CHK(status.motor_running, 1'b1)
    settings.motor_to_transformer_ratio = 8'h64; step(4);
    `CHK(status.motor_running, 1'b0)
  endtask : t_ratio
  // startup limit below range is clamped to 50; load on phase b
  task t_clamp;
    phase = 2'h1;
    settings.startup_current_limit = 10'h00a;
    level = 16'h32;
    step(3);
    `CHK(status.motor_running, 1'b1)
    hold(3, n);
    `CHK(status, 4'h5)
    level = 16'h0;
    settings.startup_current_limit = 10'hc8;
    step(4);
  endtask : t_clamp
  // main sequence
  initial begin
    error_cnt = 0; checks_done = 0; level = 16'h0; phase = 2'h0;
    settings = '{1'b1, 8'h64, 10'hc8, 6'ha, 7'h1, 13'ha};
    i_rst_n = 1'b0;
    step(2);
    i_rst_n = 1'b1;
    `CHK(status, 4'h0)
    t_normal(); t_long(); t_break(); t_off(); t_ratio();
    t_clamp();
    results();
  end
  // watchdog
  initial begin
    #100us;
    error_cnt++;
    results();
  end
endmodule : motor_start_supervisor_test
`default_nettype wire
